// ==== wrc_watchdog_reset.sv ====
`timescale 1ns/1ns
`default_nettype none
module wrc_watchdog_reset
  import wrc_pkg::*;
#(
  parameter int KEY_FAULT_DELAY_TICKS = 16,
  parameter int DELAY_W               = 8
) (
  // clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // core and supply
  input  wire logic              slow_internal_osc,
  input  wire logic              watchdog_clear_instr,
  input  wire logic              halt_instr,
  input  wire logic              low_power_mode,
  input  wire logic              supply_low,
  // reset outputs and status
  output logic                   device_reset_req,
  output logic                   pc_sp_clear,
  output logic                   port_preset,
  output logic                   timeout_status_flag,
  output logic                   powerdown_status_flag
);

  if (KEY_FAULT_DELAY_TICKS < 1 || KEY_FAULT_DELAY_TICKS > (2 ** DELAY_W)) begin : g_chk
    $error("KEY_FAULT_DELAY_TICKS does not fit DELAY_W");
  end

  localparam logic [DELAY_W-1:0] KEY_DLY_LAST = DELAY_W'(KEY_FAULT_DELAY_TICKS - 1);

  // registers
  logic [DATA_W-1:0]    watchdog_control_reg_q;
  logic [DATA_W-1:0]    watchdog_control_reg_d;
  logic [RC_FLAGS-1:0]  reset_cause_reg_q;
  logic [RC_FLAGS-1:0]  reset_cause_reg_d;
  logic [DATA_W-1:0]    brownout_level_reg_q;
  logic [DATA_W-1:0]    brownout_level_reg_d;
  logic [1:0]           brownout_filter_reg_q;
  logic [1:0]           brownout_filter_reg_d;
  logic                 timeout_q;
  logic                 timeout_d;
  logic                 pdown_q;
  logic                 pdown_d;
  logic [DATA_W-1:0]    rdata_q;
  logic [DATA_W-1:0]    rdata_d;
  // counters, oscillator edge flop and parked clear
  logic [WDT_CNT_W-1:0] wdt_cnt_q;
  logic [WDT_CNT_W-1:0] wdt_cnt_d;
  logic [DELAY_W-1:0]   key_dly_q;
  logic [DELAY_W-1:0]   key_dly_d;
  logic [DELAY_W-1:0]   lvl_dly_q;
  logic [DELAY_W-1:0]   lvl_dly_d;
  logic [7:0]           bo_cnt_q;
  logic [7:0]           bo_cnt_d;
  logic                 osc_q;
  logic                 clr_pend_q;
  logic                 clr_pend_d;
  // reset outputs
  logic                 reset_req_q;
  logic                 pc_sp_clear_q;
  logic                 port_preset_q;

  // decode
  logic [4:0]           watchdog_key_field;
  logic [2:0]           watchdog_period_select;
  logic [7:0]           brownout_level_code;
  logic [1:0]           brownout_filter_select;
  logic                 tick;
  logic                 key_ok;
  logic                 level_ok;
  logic                 wdt_ovf;
  logic                 wdt_full;
  logic                 wdt_sleep_ovf;
  logic                 key_fire;
  logic                 lvl_fire;
  logic                 bo_active;
  logic                 brownout_reset;
  logic                 full_reset;
  logic                 wr_ctrl;
  logic                 wr_cause;
  logic                 wr_level;
  logic                 wr_filter;
  logic [RC_FLAGS-1:0]  cause_set;
  logic [RC_FLAGS-1:0]  cause_clr;

  assign watchdog_key_field     = watchdog_control_reg_q[WDT_KEY_MSB:WDT_KEY_LSB];
  assign watchdog_period_select = watchdog_control_reg_q[WDT_SEL_MSB:WDT_SEL_LSB];
  assign brownout_level_code    = brownout_level_reg_q;
  assign brownout_filter_select = brownout_filter_reg_q;

  assign wr_ctrl   = reg_wr && (reg_addr == OFS_WDT_CTRL);
  assign wr_cause  = reg_wr && (reg_addr == OFS_RST_CAUSE);
  assign wr_level  = reg_wr && (reg_addr == OFS_BO_LEVEL);
  assign wr_filter = reg_wr && (reg_addr == OFS_BO_FILTER);

  // slow oscillator rising edge
  // input taken as synchronous, so a single flop suffices for the edge
  assign tick = slow_internal_osc && !osc_q;

  assign key_ok = (watchdog_key_field == WDT_KEY_EN_A) || (watchdog_key_field == WDT_KEY_EN_B);
  assign level_ok = wrc_level_legal(brownout_level_code);

  // overflow at selected terminal
  // compare with >= so a shorter period picked mid-count still overflows at once
  assign wdt_ovf = tick && key_ok && !clr_pend_q &&
                   (wdt_cnt_q >= wrc_wdt_terminal(watchdog_period_select));
  assign wdt_full      = wdt_ovf && !low_power_mode;
  assign wdt_sleep_ovf = wdt_ovf && low_power_mode;

  assign key_fire = !key_ok && tick && (key_dly_q == KEY_DLY_LAST);
  assign lvl_fire = !level_ok && tick && (lvl_dly_q == KEY_DLY_LAST);

  assign bo_active = supply_low && !low_power_mode;
  assign brownout_reset = bo_active && tick &&
                          (bo_cnt_q == wrc_bo_threshold(brownout_filter_select) - 8'h01);

  assign full_reset = wdt_full || key_fire || lvl_fire || brownout_reset;

  // clear requests held until tick
  // a request is parked so it cannot be lost between oscillator edges
  assign clr_pend_d = watchdog_clear_instr || halt_instr || (clr_pend_q && !tick);

  always_comb begin
    wdt_cnt_d = wdt_cnt_q;
    if (full_reset || !key_ok) begin
      wdt_cnt_d = '0;
    end else if (tick) begin
      if (clr_pend_q || wdt_ovf) begin
        wdt_cnt_d = '0;
      end else begin
        wdt_cnt_d = wdt_cnt_q + 18'h00001;
      end
    end
  end

  always_comb begin
    key_dly_d = key_dly_q;
    if (key_ok || full_reset) begin
      key_dly_d = '0;
    end else if (tick) begin
      key_dly_d = key_dly_q + DELAY_W'(1);
    end
  end

  always_comb begin
    lvl_dly_d = lvl_dly_q;
    if (level_ok || full_reset) begin
      lvl_dly_d = '0;
    end else if (tick) begin
      lvl_dly_d = lvl_dly_q + DELAY_W'(1);
    end
  end

  always_comb begin
    bo_cnt_d = bo_cnt_q;
    if (!bo_active || full_reset) begin
      bo_cnt_d = '0;
    end else if (tick) begin
      bo_cnt_d = bo_cnt_q + 8'h01;
    end
  end

  always_comb begin
    watchdog_control_reg_d = watchdog_control_reg_q;
    if (full_reset) begin
      watchdog_control_reg_d = WDT_CTRL_POR;
    end else if (wr_ctrl) begin
      watchdog_control_reg_d = reg_wdata;
    end
  end

  // bad code restores level
  // a genuine brownout reset leaves the level code as it is
  always_comb begin
    brownout_level_reg_d = brownout_level_reg_q;
    if (lvl_fire) begin
      brownout_level_reg_d = BO_LEVEL_POR;
    end else if (wr_level) begin
      brownout_level_reg_d = reg_wdata;
    end
  end

  assign brownout_filter_reg_d = wr_filter ? reg_wdata[1:0] : brownout_filter_reg_q;

  assign cause_set[RC_WDT_KEY_BIT] = key_fire;
  assign cause_set[RC_BO_KEY_BIT]  = lvl_fire;
  assign cause_set[RC_BO_RST_BIT]  = brownout_reset;

  for (genvar i = 0; i < RC_FLAGS; i++) begin : g_cause
    // set beats a clear landing in the same cycle
    assign cause_clr[i]         = wr_cause && !reg_wdata[i];
    assign reset_cause_reg_d[i] = cause_set[i] || (reset_cause_reg_q[i] && !cause_clr[i]);
  end

  assign timeout_d = wdt_ovf || (timeout_q && !watchdog_clear_instr && !halt_instr);
  assign pdown_d   = halt_instr || (pdown_q && !watchdog_clear_instr);

  always_comb begin
    rdata_d = '0;
    if (reg_addr == OFS_WDT_CTRL) begin
      rdata_d = watchdog_control_reg_q;
    end else if (reg_addr == OFS_RST_CAUSE) begin
      rdata_d = {5'h00, reset_cause_reg_q};
    end else if (reg_addr == OFS_BO_LEVEL) begin
      rdata_d = brownout_level_reg_q;
    end else if (reg_addr == OFS_BO_FILTER) begin
      rdata_d = {6'h00, brownout_filter_reg_q};
    end else if (reg_addr == OFS_CORE_STAT) begin
      rdata_d = {6'h00, pdown_q, timeout_q};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_control_reg_q <= WDT_CTRL_POR;
      brownout_level_reg_q   <= BO_LEVEL_POR;
      brownout_filter_reg_q  <= BO_FILTER_POR;
      reset_cause_reg_q      <= RST_CAUSE_POR;
      timeout_q              <= 1'b0;
      pdown_q                <= 1'b0;
      rdata_q                <= '0;
    end else begin
      watchdog_control_reg_q <= watchdog_control_reg_d;
      brownout_level_reg_q   <= brownout_level_reg_d;
      brownout_filter_reg_q  <= brownout_filter_reg_d;
      reset_cause_reg_q      <= reset_cause_reg_d;
      timeout_q              <= timeout_d;
      pdown_q                <= pdown_d;
      rdata_q                <= reg_rd ? rdata_d : '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt_q  <= '0;
      key_dly_q  <= '0;
      lvl_dly_q  <= '0;
      bo_cnt_q   <= '0;
      osc_q      <= 1'b0;
      clr_pend_q <= 1'b0;
    end else begin
      wdt_cnt_q  <= wdt_cnt_d;
      key_dly_q  <= key_dly_d;
      lvl_dly_q  <= lvl_dly_d;
      bo_cnt_q   <= bo_cnt_d;
      osc_q      <= slow_internal_osc;
      clr_pend_q <= clr_pend_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_req_q   <= 1'b1;
      pc_sp_clear_q <= 1'b1;
      port_preset_q <= 1'b1;
    end else begin
      reset_req_q   <= full_reset;
      pc_sp_clear_q <= full_reset || wdt_sleep_ovf;
      port_preset_q <= full_reset;
    end
  end

  assign reg_rdata             = rdata_q;
  assign device_reset_req      = reset_req_q;
  assign pc_sp_clear           = pc_sp_clear_q;
  assign port_preset           = port_preset_q;
  assign timeout_status_flag   = timeout_q;
  assign powerdown_status_flag = pdown_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  run_overflow_a: assert property (
    wdt_full |=> reset_req_q && pc_sp_clear_q && timeout_q)
    else $error("running overflow did not reset");

  sleep_overflow_a: assert property (
    wdt_sleep_ovf && !key_fire && !lvl_fire |=> pc_sp_clear_q && !reset_req_q && timeout_q)
    else $error("low-power overflow wrong");

  key_flag_clear_a: assert property (
    $fell(reset_cause_reg_q[RC_WDT_KEY_BIT]) |-> $past(wr_cause && !reg_wdata[RC_WDT_KEY_BIT]))
    else $error("key fault flag cleared without write");

  cause_reserved_a: assert property (
    reg_rd && reg_addr == OFS_RST_CAUSE |=> reg_rdata[7:3] == 5'h00)
    else $error("reset cause upper bits not zero");

  brownout_flag_a: assert property (
    brownout_reset |=> reset_req_q && reset_cause_reg_q[RC_BO_RST_BIT])
    else $error("brownout reset not flagged");

  level_restore_a: assert property (
    lvl_fire |=> brownout_level_reg_q == BO_LEVEL_POR && reset_cause_reg_q[RC_BO_KEY_BIT])
    else $error("bad level code not restored");

  key_fault_reset_a: assert property (
    key_fire |=> reset_req_q && reset_cause_reg_q[RC_WDT_KEY_BIT]
                 && watchdog_control_reg_q == WDT_CTRL_POR)
    else $error("key fault reset wrong");

  key_disable_a: assert property (
    !key_ok |=> wdt_cnt_q == '0)
    else $error("counter ran with bad key");

  halt_clear_a: assert property (
    halt_instr |=> clr_pend_q && pdown_q)
    else $error("halt clear not parked");

  pend_clear_a: assert property (
    clr_pend_q && tick && !full_reset && key_ok |=> wdt_cnt_q == '0)
    else $error("parked clear did not clear count");

  sleep_brownout_a: assert property (
    low_power_mode |=> bo_cnt_q == 8'h00 && !$past(brownout_reset))
    else $error("brownout active in low power");

  por_values_a: assert property (
    $rose(port_preset_q) or (port_preset_q && $past(!rst_b)) |->
      watchdog_control_reg_q == WDT_CTRL_POR)
    else $error("power-on control value wrong");

  cover_run_ovf_c:   cover property (wdt_full);
  cover_sleep_ovf_c: cover property (wdt_sleep_ovf);
  cover_brownout_c:  cover property (brownout_reset);
  cover_key_fault_c: cover property (key_fire);

endmodule : wrc_watchdog_reset
`default_nettype wire

// ==== wrc_pkg.sv ====
`default_nettype none
package wrc_pkg;
  // register bus
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 3;
  localparam logic [2:0]  OFS_WDT_CTRL    = 3'h0;
  localparam logic [2:0]  OFS_RST_CAUSE   = 3'h1;
  localparam logic [2:0]  OFS_BO_LEVEL    = 3'h2;
  localparam logic [2:0]  OFS_BO_FILTER   = 3'h3;
  localparam logic [2:0]  OFS_CORE_STAT   = 3'h4;
  // field positions
  localparam int          WDT_KEY_MSB     = 7;
  localparam int          WDT_KEY_LSB     = 3;
  localparam int          WDT_SEL_MSB     = 2;
  localparam int          WDT_SEL_LSB     = 0;
  localparam int          RC_WDT_KEY_BIT  = 0;
  localparam int          RC_BO_KEY_BIT   = 1;
  localparam int          RC_BO_RST_BIT   = 2;
  localparam int          RC_FLAGS        = 3;
  localparam int          ST_TIMEOUT_BIT  = 0;
  localparam int          ST_PDOWN_BIT    = 1;
  // power-on values
  localparam logic [7:0]  WDT_CTRL_POR    = 8'h53;
  localparam logic [7:0]  BO_LEVEL_POR    = 8'h55;
  localparam logic [1:0]  BO_FILTER_POR   = 2'h1;
  localparam logic [2:0]  RST_CAUSE_POR   = 3'h0;
  // key codes
  localparam logic [4:0]  WDT_KEY_EN_A    = 5'h0A;
  localparam logic [4:0]  WDT_KEY_EN_B    = 5'h15;
  localparam logic [7:0]  BO_LEVEL_B      = 8'h33;
  localparam logic [7:0]  BO_LEVEL_C      = 8'h99;
  localparam logic [7:0]  BO_LEVEL_D      = 8'hAA;
  // brownout filter times, slow oscillator periods
  localparam logic [7:0]  BO_FILT_T0      = 8'h08;
  localparam logic [7:0]  BO_FILT_T1      = 8'h20;
  localparam logic [7:0]  BO_FILT_T2      = 8'h40;
  localparam logic [7:0]  BO_FILT_T3      = 8'h80;
  // watchdog counter
  localparam int          WDT_CNT_W       = 18;

  function automatic logic [WDT_CNT_W-1:0] wrc_wdt_terminal(input logic [2:0] sel);
    logic [WDT_CNT_W-1:0] t;
    t = 18'h3FFFF;
    case (sel)
      3'h0: t = 18'h000FF;
      3'h1: t = 18'h003FF;
      3'h2: t = 18'h00FFF;
      3'h3: t = 18'h03FFF;
      3'h4: t = 18'h07FFF;
      3'h5: t = 18'h0FFFF;
      3'h6: t = 18'h1FFFF;
      default: t = 18'h3FFFF;
    endcase
    return t;
  endfunction : wrc_wdt_terminal

  function automatic logic [7:0] wrc_bo_threshold(input logic [1:0] sel);
    logic [7:0] t;
    t = BO_FILT_T3;
    case (sel)
      2'h0: t = BO_FILT_T0;
      2'h1: t = BO_FILT_T1;
      2'h2: t = BO_FILT_T2;
      default: t = BO_FILT_T3;
    endcase
    return t;
  endfunction : wrc_bo_threshold

  function automatic logic wrc_level_legal(input logic [7:0] code);
    return (code == BO_LEVEL_POR) || (code == BO_LEVEL_B) ||
           (code == BO_LEVEL_C) || (code == BO_LEVEL_D);
  endfunction : wrc_level_legal
endpackage : wrc_pkg
`default_nettype wire

// ==== wrc_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module wrc_core_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // bench commands
  input  wire logic clear_cmd,
  input  wire logic halt_cmd,
  input  wire logic keepalive,
  // wake from the watchdog
  input  wire logic pc_sp_clear,
  // instruction strobes and low-power state
  output logic      watchdog_clear_instr,
  output logic      halt_instr,
  output logic      low_power_mode
);
  logic [8:0] gap_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q                <= 9'h000;
      watchdog_clear_instr <= 1'b0;
      halt_instr           <= 1'b0;
      low_power_mode       <= 1'b0;
    end else begin
      gap_q                <= (gap_q == 9'h12B) ? 9'h000 : gap_q + 9'h001;
      watchdog_clear_instr <= clear_cmd | (keepalive & (gap_q == 9'h12B));
      halt_instr           <= halt_cmd;
      // core sleeps after halt until the pc is cleared by a wake
      low_power_mode       <= halt_cmd | (low_power_mode & ~pc_sp_clear);
    end
  end
endmodule : wrc_core_model
`default_nettype wire

// ==== wrc_watchdog_reset_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module wrc_watchdog_reset_bench;
  import wrc_pkg::*;
  // short fault delay keeps the run brief
  localparam int KEY_DLY = 3;
  logic              clk, rst_b, reg_wr, reg_rd, osc, supply_low;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic              clr_cmd, halt_cmd, keepalive, clr_instr, halt_instr, lp_mode;
  logic              dev_rst, pcsp, port_pre, to_flag, pd_flag, full, any;
  logic [7:0]        v;
  logic [7:0]        lv [4] = '{BO_LEVEL_POR, BO_LEVEL_B, BO_LEVEL_C, BO_LEVEL_D};
  int                miscompares, num_checks, ticks, cyc, oc, el, seed, thr;
  int                exp_reg [8] = '{WDT_CTRL_POR, 0, BO_LEVEL_POR, BO_FILTER_POR, 0, 0, 0, 0};

  wrc_watchdog_reset #(.KEY_FAULT_DELAY_TICKS(KEY_DLY)) DUT (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_internal_osc(osc), .watchdog_clear_instr(clr_instr), .halt_instr(halt_instr),
    .low_power_mode(lp_mode), .supply_low(supply_low), .device_reset_req(dev_rst),
    .pc_sp_clear(pcsp), .port_preset(port_pre), .timeout_status_flag(to_flag),
    .powerdown_status_flag(pd_flag));

  wrc_core_model CORE (
    .clk(clk), .rst_b(rst_b), .clear_cmd(clr_cmd), .halt_cmd(halt_cmd),
    .keepalive(keepalive), .pc_sp_clear(pcsp), .watchdog_clear_instr(clr_instr),
    .halt_instr(halt_instr), .low_power_mode(lp_mode));

  always #5 clk = ~clk;

  // slow oscillator: 8 clk per period, counted in ticks
  always @(posedge clk) begin
    oc <= (oc == 3) ? 0 : oc + 1;
    if (oc == 3) begin
      osc <= ~osc;
      if (!osc) ticks <= ticks + 1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask : chk8

  task automatic chk_ticks(input string name, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, g);
      miscompares++;
    end
  endtask : chk_ticks

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      OFS_WDT_CTRL:  exp_reg[0] = d;
      OFS_RST_CAUSE: exp_reg[1] = exp_reg[1] & d;
      OFS_BO_LEVEL:  exp_reg[2] = d;
      OFS_BO_FILTER: exp_reg[3] = d & 3;
      default: ;
    endcase
  endtask : wr

  task automatic rd_chk(input logic [2:0] a);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk8($sformatf("register %0d", a), 8'(exp_reg[a]), reg_rdata);
  endtask : rd_chk

  task automatic pulse(input bit h);
    @(posedge clk);
    if (h) halt_cmd <= 1'b1;
    else clr_cmd <= 1'b1;
    @(posedge clk);
    halt_cmd <= 1'b0;
    clr_cmd  <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // waits up to lim ticks for a pc clear; full reset shows on port preset too
  task automatic evt(input int lim, input logic w_any, input logic w_full, input int lo,
                     input int hi);
    int   t0;
    logic pp;
    t0   = ticks;
    any  = 1'b0;
    full = 1'b0;
    pp   = 1'b0;
    for (int i = 0; i < lim * 8 && !any; i++) begin
      @(posedge clk);
      #1;
      if (pcsp === 1'b1) begin
        any  = 1'b1;
        full = dev_rst;
        pp   = port_pre;
        el   = ticks - t0;
      end
    end
    chk8("reset event", {7'h0, w_any}, {7'h0, any});
    if (w_any) begin
      chk8("reset kind", {6'h0, w_full, w_full}, {6'h0, pp, full});
      chk_ticks("ticks to reset", lo, hi, el);
    end
  endtask : evt

  task automatic done_t(input string s);
    $display("test %s finished, mismatches so far %0d", s, miscompares);
  endtask : done_t

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clk = 0;
    rst_b = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 0;
    reg_wdata = 0;
    osc = 0;
    supply_low = 0;
    clr_cmd = 0;
    halt_cmd = 0;
    keepalive = 0;
    oc = 0;
    ticks = 0;
    cyc = 0;
    miscompares = 0;
    num_checks = 0;
    seed = $urandom(85064);
    repeat (12) @(posedge clk);
    chk8("reset outputs", 8'h07, {5'h0, dev_rst, pcsp, port_pre});
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(3'(a));
    chk8("status flags", 8'h00, {6'h0, pd_flag, to_flag});
    done_t("power_on");

    wr(OFS_WDT_CTRL, 8'h50);
    @(posedge clk) keepalive <= 1'b1;
    evt(300, 1'b0, 1'b0, 0, 0);
    @(posedge clk) keepalive <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      thr = (p == 0) ? 256 : 1024;
      wr(OFS_WDT_CTRL, 8'h50 | 8'(p));
      pulse(1'b0);
      evt(thr + 3, 1'b1, 1'b1, thr - 1, thr + 1);
      exp_reg[0] = WDT_CTRL_POR;
      exp_reg[4] = 1;
      rd_chk(OFS_WDT_CTRL);
      rd_chk(OFS_CORE_STAT);
      chk8("status pins", 8'(exp_reg[4]), {6'h0, pd_flag, to_flag});
    end
    // clear is parked until a tick, so wait past one
    pulse(1'b0);
    repeat (12) @(posedge clk);
    exp_reg[4] = 0;
    rd_chk(OFS_CORE_STAT);
    done_t("running_overflow");

    wr(OFS_WDT_CTRL, 8'hA8);
    rd_chk(OFS_WDT_CTRL);
    pulse(1'b1);
    exp_reg[4] = 2;
    rd_chk(OFS_CORE_STAT);
    @(posedge clk) supply_low <= 1'b1;
    evt(259, 1'b1, 1'b0, 255, 257);
    @(posedge clk) supply_low <= 1'b0;
    exp_reg[4] = 3;
    rd_chk(OFS_CORE_STAT);
    chk8("status pins", 8'(exp_reg[4]), {6'h0, pd_flag, to_flag});
    rd_chk(OFS_WDT_CTRL);
    @(posedge clk) keepalive <= 1'b1;
    done_t("low_power_overflow");

    do v = 8'($urandom); while (v[7:3] == WDT_KEY_EN_A || v[7:3] == WDT_KEY_EN_B);
    wr(OFS_WDT_CTRL, v);
    evt(KEY_DLY + 3, 1'b1, 1'b1, KEY_DLY - 1, KEY_DLY + 1);
    exp_reg[0] = WDT_CTRL_POR;
    exp_reg[1] = 1;
    rd_chk(OFS_WDT_CTRL);
    rd_chk(OFS_RST_CAUSE);
    wr(OFS_RST_CAUSE, 8'hFF);
    rd_chk(OFS_RST_CAUSE);
    wr(OFS_RST_CAUSE, 8'hFE);
    rd_chk(OFS_RST_CAUSE);
    done_t("key_fault");

    foreach (lv[i]) begin
      wr(OFS_BO_LEVEL, lv[i]);
      rd_chk(OFS_BO_LEVEL);
    end
    evt(20, 1'b0, 1'b0, 0, 0);
    do v = 8'($urandom); while (v == lv[0] || v == lv[1] || v == lv[2] || v == lv[3]);
    wr(OFS_BO_LEVEL, v);
    evt(KEY_DLY + 3, 1'b1, 1'b1, KEY_DLY - 1, KEY_DLY + 1);
    exp_reg[0] = WDT_CTRL_POR;
    exp_reg[1] = 2;
    exp_reg[2] = BO_LEVEL_POR;
    rd_chk(OFS_BO_LEVEL);
    rd_chk(OFS_RST_CAUSE);
    done_t("level_fault");

    for (int f = 0; f < 4; f++) begin
      thr = (f == 0) ? 8 : (8 << (f + 1));
      wr(OFS_BO_FILTER, 8'(f));
      rd_chk(OFS_BO_FILTER);
      @(posedge clk) supply_low <= 1'b1;
      evt(thr - 2, 1'b0, 1'b0, 0, 0);
      @(posedge clk) supply_low <= 1'b0;
      repeat (20) @(posedge clk);
      @(posedge clk) supply_low <= 1'b1;
      evt(thr + 3, 1'b1, 1'b1, thr - 1, thr + 1);
      @(posedge clk) supply_low <= 1'b0;
      exp_reg[0] = WDT_CTRL_POR;
      exp_reg[1] = exp_reg[1] | 4;
      rd_chk(OFS_RST_CAUSE);
      rd_chk(OFS_BO_LEVEL);
      rd_chk(OFS_BO_FILTER);
    end
    done_t("brownout");
    tally_and_finish();
  end
endmodule : wrc_watchdog_reset_bench
`default_nettype wire
